// ==== inc/asfi_regs.svh ====
`ifndef ASFI_REGS_SVH
`define ASFI_REGS_SVH

// Register byte offsets
`define ASFI_OFS_CTRL 8'h00
`define ASFI_OFS_CLKCTRL0 8'h04
`define ASFI_OFS_CLKCTRL1 8'h08
`define ASFI_OFS_IRQ_ENABLE_CLEAR 8'h0C
`define ASFI_OFS_IRQ_ENABLE_SET 8'h10
`define ASFI_OFS_INTFLAG 8'h14
`define ASFI_OFS_DATA0 8'h30
`define ASFI_OFS_DATA1 8'h34

// Control register fields
`define ASFI_CTRL_SWRST 0
`define ASFI_CTRL_ENABLE 1
`define ASFI_CTRL_CKEN_LO 2
`define ASFI_CTRL_CKEN_HI 3

// Frame control fields
`define ASFI_FC_DELAY 7
`define ASFI_FC_WIDTH_HI 6
`define ASFI_FC_WIDTH_LO 5
`define ASFI_FC_SLOTS_HI 4
`define ASFI_FC_SLOTS_LO 2
`define ASFI_FC_SIZE_HI 1
`define ASFI_FC_SIZE_LO 0

// Interrupt enable and flag fields
`define ASFI_IRQ_RXRDY_LO 0
`define ASFI_IRQ_RXOR_LO 4
`define ASFI_IRQ_TXRDY_LO 8
`define ASFI_IRQ_TXUR_LO 12
`define ASFI_IRQ_MASK 16'h3333

// Reset values
`define ASFI_RST_IRQ 16'h0000
`define ASFI_RST_CLKCTRL 8'h00
`define ASFI_RST_WORD 32'h0000_0000

// Slot sizes in serial bits
`define ASFI_SLOT_8 6'h08
`define ASFI_SLOT_16 6'h10
`define ASFI_SLOT_24 6'h18
`define ASFI_SLOT_32 6'h20

`endif

// ==== inc/asfi_pkg.sv ====
package asfi_pkg;

	typedef enum logic [1:0] {
		ASFI_FS_SLOT = 2'b00,
		ASFI_FS_HALF = 2'b01,
		ASFI_FS_BIT = 2'b10,
		ASFI_FS_BURST = 2'b11
	} asfi_fs_width_e;

	typedef enum logic [1:0] {
		ASFI_FG_IDLE = 2'b00,
		ASFI_FG_RUN = 2'b01,
		ASFI_FG_WAIT = 2'b10,
		ASFI_FG_BURST = 2'b11
	} asfi_fg_state_e;

	typedef struct packed {
		logic data_delay_sel;
		asfi_fs_width_e sync_pulse_width;
		logic [2:0] slot_count;
		logic [1:0] slot_bits;
	} asfi_frame_cfg_s;

	typedef struct packed {
		logic [1:0] tx_underrun;
		logic [1:0] tx_word_wanted;
		logic [1:0] rx_overrun;
		logic [1:0] rx_word_available;
	} asfi_seq_evt_s;

endpackage

// ==== rtl/asfi_frame_gen.sv ====
`timescale 1ns/10ps
`include "asfi_regs.svh"

module asfi_frame_gen
	import asfi_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic enable,
	input wire logic bit_tick,
	input wire asfi_frame_cfg_s cfg,
	input wire logic xfer_req,
	output logic fs,
	output logic data_start
);

	function automatic logic [5:0] asfi_slot_len(input logic [1:0] code);
		case (code)
			2'h0: asfi_slot_len = `ASFI_SLOT_8;
			2'h1: asfi_slot_len = `ASFI_SLOT_16;
			2'h2: asfi_slot_len = `ASFI_SLOT_24;
			default: asfi_slot_len = `ASFI_SLOT_32;
		endcase
	endfunction

	asfi_fg_state_e state, next_state;
	logic [7:0] pos, next_pos;
	logic next_fs, next_data_start, pend, next_pend;
	logic [5:0] slot_len;
	logic [8:0] frame_len;
	logic frame_last, burst_last, fs_at, is_burst, take;

	always_comb begin
		slot_len = asfi_slot_len(cfg.slot_bits);
		frame_len = ({6'h00, cfg.slot_count} + 9'h001) * {3'h0, slot_len};
		frame_last = {1'b0, pos} >= (frame_len - 9'h001);
		burst_last = {1'b0, pos} >= ({3'h0, slot_len} - 9'h001 + {8'h00, cfg.data_delay_sel});
		is_burst = cfg.sync_pulse_width == ASFI_FS_BURST;
		case (cfg.sync_pulse_width)
			ASFI_FS_SLOT: fs_at = {1'b0, pos} < {3'h0, slot_len};
			ASFI_FS_HALF: fs_at = {pos, 1'b0} < frame_len;
			ASFI_FS_BIT: fs_at = pos == 8'h00;
			default: fs_at = 1'b0;
		endcase
		take = bit_tick && (pend || xfer_req);
		next_state = state;
		next_pos = pos;
		next_fs = fs;
		next_data_start = 1'b0;
		next_pend = pend || xfer_req;
		if (!enable) begin
			next_state = ASFI_FG_IDLE;
			next_pos = 8'h00;
			next_fs = 1'b0;
			next_pend = 1'b0;
		end else begin
			case (state)
				ASFI_FG_IDLE: begin
					next_pos = 8'h00;
					next_state = is_burst ? ASFI_FG_WAIT : ASFI_FG_RUN;
				end
				ASFI_FG_RUN: begin
					// Free running: no request is needed for a frame
					next_pend = 1'b0;
					if (bit_tick) begin
						next_fs = fs_at;
						next_data_start = pos == {7'h00, cfg.data_delay_sel};
						next_pos = frame_last ? 8'h00 : pos + 8'h01;
						if (frame_last && is_burst) begin
							next_state = ASFI_FG_WAIT;
						end
					end
				end
				ASFI_FG_WAIT: begin
					if (!is_burst) begin
						next_state = ASFI_FG_RUN;
						next_pos = 8'h00;
					end else if (take) begin
						next_fs = 1'b1;
						next_data_start = !cfg.data_delay_sel;
						next_pos = 8'h01;
						next_pend = 1'b0;
						next_state = ASFI_FG_BURST;
					end else if (bit_tick) begin
						next_fs = 1'b0;
					end
				end
				ASFI_FG_BURST: begin
					if (bit_tick) begin
						// One-bit sync, then exactly one slot of data
						next_fs = 1'b0;
						next_data_start = pos == {7'h00, cfg.data_delay_sel};
						next_pos = burst_last ? 8'h00 : pos + 8'h01;
						if (burst_last) begin
							next_state = ASFI_FG_WAIT;
						end
					end
				end
				default: next_state = ASFI_FG_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ASFI_FG_IDLE;
			pos <= 8'h00;
			fs <= 1'b0;
			data_start <= 1'b0;
			pend <= 1'b0;
		end else begin
			state <= next_state;
			pos <= next_pos;
			fs <= next_fs;
			data_start <= next_data_start;
			pend <= next_pend;
		end
	end

	a_burst_fs_req: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(fs) && $past(state) == ASFI_FG_WAIT |-> $past(pend || xfer_req))
		else $error("burst sync without request");

	a_bit_fs_width: assert property (@(posedge pclk) disable iff (!presetn)
		state == ASFI_FG_RUN && cfg.sync_pulse_width == ASFI_FS_BIT && fs && bit_tick
		&& pos == 8'h01 |=> !fs)
		else $error("bit wide sync longer than one bit");

	a_burst_lj_start: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(fs) && $past(state) == ASFI_FG_WAIT && !cfg.data_delay_sel |-> data_start)
		else $error("left justified burst data not at sync");

endmodule

// ==== rtl/asfi_top.sv ====
`timescale 1ns/10ps
`include "asfi_regs.svh"
// Notes on behaviour
// - Delay 0 puts first data bit at sync; delay 1 one bit later.
// - Sync width codes: one slot, half frame, one bit.
// - Non-burst enabled unit runs frames continuously without requests.
// - Burst code: one-bit sync only on request, one sample each.
// - Frame holds slot count field plus one slots; field bits 4:2.
// - Slot size codes 0..3 give 8, 16, 24, 32 bits.
// - Enable-clear write one disables underrun interrupt; zero ignored.
// - Enable-clear write one disables transmit ready interrupt; zero ignored.
// - Enable-clear write one disables overrun interrupt; zero ignored.
// - Enable-clear write one disables receive ready interrupt; zero ignored.
// - Enable-set write one enables underrun interrupt; zero ignored.
// - Enable-set write one enables transmit ready interrupt; zero ignored.
// - Enable-set write one enables overrun interrupt; zero ignored.
// - Both enable registers read enabled sources as one; reset zero.
// - Enable-set write one enables receive ready interrupt; zero ignored.
// - Underrun and overrun flags set on event, cleared by writing one.
// - Transmit ready flag cleared by data register write or writing one.
// - Receive ready flag cleared by data register read or writing one.

module asfi_top
	import asfi_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] sck_in,
	input wire logic [1:0] xfer_req,
	input wire asfi_seq_evt_s seq_evt,
	input wire logic [1:0][31:0] rx_sample,
	output logic [1:0][31:0] tx_sample,
	output logic [1:0] fs_out,
	output logic [1:0] data_start,
	output logic irq
);

	function automatic logic asfi_mapped(input logic [7:0] a);
		case (a)
			`ASFI_OFS_CTRL, `ASFI_OFS_CLKCTRL0, `ASFI_OFS_CLKCTRL1,
			`ASFI_OFS_IRQ_ENABLE_CLEAR, `ASFI_OFS_IRQ_ENABLE_SET, `ASFI_OFS_INTFLAG,
			`ASFI_OFS_DATA0, `ASFI_OFS_DATA1: asfi_mapped = 1'b1;
			default: asfi_mapped = 1'b0;
		endcase
	endfunction

	function automatic logic [15:0] asfi_pair(input logic [1:0] v, input int lo);
		asfi_pair = 16'(v) << lo;
	endfunction

	logic ctrl_enable, next_ctrl_enable;
	logic [1:0] cken, next_cken;
	logic [1:0][7:0] clkctrl, next_clkctrl;
	logic [15:0] irq_en, next_irq_en;
	logic [15:0] flags, next_flags;
	logic [1:0][31:0] next_tx_sample;
	logic [31:0] next_prdata, rd_value;
	logic next_pready, next_pslverr, next_irq;
	logic wr, rd, swrst;
	logic [15:0] ev, clr, wmask;

	// Serial clock pins are asynchronous: two flops, then edge detect
	logic [1:0] sck_s1, sck_s2, sck_s3;
	logic [1:0] bit_tick;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_s1 <= 2'h0;
			sck_s2 <= 2'h0;
			sck_s3 <= 2'h0;
		end else begin
			sck_s1 <= sck_in;
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
		end
	end

	assign bit_tick = sck_s2 & ~sck_s3;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_unit
			asfi_frame_cfg_s cfg;
			assign cfg = asfi_frame_cfg_s'(clkctrl[g]);
			asfi_frame_gen u_frame (
				.pclk(pclk),
				.presetn(presetn),
				.enable(ctrl_enable && cken[g]),
				.bit_tick(bit_tick[g]),
				.cfg(cfg),
				.xfer_req(xfer_req[g]),
				.fs(fs_out[g]),
				.data_start(data_start[g])
			);
		end
	endgenerate

	assign wr = psel && penable && pready && pwrite;
	assign rd = psel && penable && pready && !pwrite;
	assign swrst = wr && paddr == `ASFI_OFS_CTRL && pwdata[`ASFI_CTRL_SWRST];
	assign wmask = pwdata[15:0] & `ASFI_IRQ_MASK;

	assign ev = asfi_pair(seq_evt.tx_underrun, `ASFI_IRQ_TXUR_LO)
		| asfi_pair(seq_evt.tx_word_wanted, `ASFI_IRQ_TXRDY_LO)
		| asfi_pair(seq_evt.rx_overrun, `ASFI_IRQ_RXOR_LO)
		| asfi_pair(seq_evt.rx_word_available, `ASFI_IRQ_RXRDY_LO);

	always_comb begin
		rd_value = `ASFI_RST_WORD;
		case (paddr)
			`ASFI_OFS_CTRL: begin
				rd_value[`ASFI_CTRL_ENABLE] = ctrl_enable;
				rd_value[`ASFI_CTRL_CKEN_HI:`ASFI_CTRL_CKEN_LO] = cken;
			end
			`ASFI_OFS_CLKCTRL0: rd_value[7:0] = clkctrl[0];
			`ASFI_OFS_CLKCTRL1: rd_value[7:0] = clkctrl[1];
			`ASFI_OFS_IRQ_ENABLE_CLEAR: rd_value[15:0] = irq_en;
			`ASFI_OFS_IRQ_ENABLE_SET: rd_value[15:0] = irq_en;
			`ASFI_OFS_INTFLAG: rd_value[15:0] = flags;
			`ASFI_OFS_DATA0: rd_value = rx_sample[0];
			`ASFI_OFS_DATA1: rd_value = rx_sample[1];
			default: rd_value = `ASFI_RST_WORD;
		endcase
	end

	always_comb begin
		next_ctrl_enable = ctrl_enable;
		next_cken = cken;
		next_clkctrl = clkctrl;
		next_irq_en = irq_en;
		next_tx_sample = tx_sample;
		clr = 16'h0000;
		// Answer one cycle after setup; read data captured at setup
		next_pready = psel && !penable;
		next_prdata = (psel && !penable) ? rd_value : prdata;
		next_pslverr = psel && !penable && !asfi_mapped(paddr);
		if (wr) begin
			case (paddr)
				`ASFI_OFS_CTRL: begin
					next_ctrl_enable = pwdata[`ASFI_CTRL_ENABLE];
					next_cken = pwdata[`ASFI_CTRL_CKEN_HI:`ASFI_CTRL_CKEN_LO];
				end
				// Frame format only changes while the module is disabled
				`ASFI_OFS_CLKCTRL0: if (!ctrl_enable) begin
					next_clkctrl[0] = pwdata[7:0];
				end
				`ASFI_OFS_CLKCTRL1: if (!ctrl_enable) begin
					next_clkctrl[1] = pwdata[7:0];
				end
				`ASFI_OFS_IRQ_ENABLE_CLEAR: next_irq_en = irq_en & ~wmask;
				`ASFI_OFS_IRQ_ENABLE_SET: next_irq_en = irq_en | wmask;
				`ASFI_OFS_INTFLAG: clr = wmask;
				`ASFI_OFS_DATA0: begin
					next_tx_sample[0] = pwdata;
					clr[`ASFI_IRQ_TXRDY_LO] = 1'b1;
				end
				`ASFI_OFS_DATA1: begin
					next_tx_sample[1] = pwdata;
					clr[`ASFI_IRQ_TXRDY_LO + 1] = 1'b1;
				end
				default: clr = 16'h0000;
			endcase
		end
		if (rd && paddr == `ASFI_OFS_DATA0) begin
			clr[`ASFI_IRQ_RXRDY_LO] = 1'b1;
		end
		if (rd && paddr == `ASFI_OFS_DATA1) begin
			clr[`ASFI_IRQ_RXRDY_LO + 1] = 1'b1;
		end
		// A new event beats a clear in the same cycle
		next_flags = ((flags & ~clr) | ev) & `ASFI_IRQ_MASK;
		if (swrst) begin
			next_ctrl_enable = 1'b0;
			next_cken = 2'h0;
			next_clkctrl = {2{`ASFI_RST_CLKCTRL}};
			next_irq_en = `ASFI_RST_IRQ;
			next_flags = `ASFI_RST_IRQ;
			next_tx_sample = {2{`ASFI_RST_WORD}};
		end
		next_irq = |(next_flags & next_irq_en);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_enable <= 1'b0;
			cken <= 2'h0;
			clkctrl <= {2{`ASFI_RST_CLKCTRL}};
			irq_en <= `ASFI_RST_IRQ;
			flags <= `ASFI_RST_IRQ;
			tx_sample <= {2{`ASFI_RST_WORD}};
			prdata <= `ASFI_RST_WORD;
			pready <= 1'b0;
			pslverr <= 1'b0;
			irq <= 1'b0;
		end else begin
			ctrl_enable <= next_ctrl_enable;
			cken <= next_cken;
			clkctrl <= next_clkctrl;
			irq_en <= next_irq_en;
			flags <= next_flags;
			tx_sample <= next_tx_sample;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			irq <= next_irq;
		end
	end

	a_enset_sets: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == `ASFI_OFS_IRQ_ENABLE_SET && !swrst |=>
		(irq_en & $past(wmask)) == $past(wmask) && (irq_en & ~$past(wmask)) == $past(irq_en & ~wmask))
		else $error("enable set write wrong");

	a_enclr_clears: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == `ASFI_OFS_IRQ_ENABLE_CLEAR |=>
		(irq_en & $past(wmask)) == 16'h0000 && (irq_en & ~$past(wmask)) == $past(irq_en & ~wmask))
		else $error("enable clear write wrong");

	a_enable_readback: assert property (@(posedge pclk) disable iff (!presetn)
		pready && (paddr == `ASFI_OFS_IRQ_ENABLE_CLEAR || paddr == `ASFI_OFS_IRQ_ENABLE_SET)
		|-> prdata == {16'h0000, $past(irq_en)})
		else $error("enable registers read back differently");

	a_event_wins: assert property (@(posedge pclk) disable iff (!presetn)
		(ev & clr) != 16'h0000 && !swrst |=> (flags & $past(ev)) == $past(ev))
		else $error("event lost against clear");

	a_txrdy_data_clr: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == `ASFI_OFS_DATA0 && !seq_evt.tx_word_wanted[0]
		|=> !flags[`ASFI_IRQ_TXRDY_LO])
		else $error("data write did not clear transmit ready");

	a_rxrdy_data_clr: assert property (@(posedge pclk) disable iff (!presetn)
		rd && paddr == `ASFI_OFS_DATA1 && !seq_evt.rx_word_available[1]
		|=> !flags[`ASFI_IRQ_RXRDY_LO + 1])
		else $error("data read did not clear receive ready");

	a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
		##1 irq == (|(flags & irq_en)))
		else $error("interrupt output disagrees with flags and enables");

	a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready ##1 !pready)
		else $error("slave answer not after one cycle");

	a_slverr_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !asfi_mapped(paddr) |=> pslverr && pready)
		else $error("unmapped address not refused");

	a_clkctrl_locked: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == `ASFI_OFS_CLKCTRL0 && ctrl_enable |=> $stable(clkctrl[0]))
		else $error("frame format changed while enabled");

	a_soft_reset_clears: assert property (@(posedge pclk) disable iff (!presetn)
		swrst |=> !ctrl_enable && irq_en == `ASFI_RST_IRQ
		&& flags == `ASFI_RST_IRQ)
		else $error("software reset left state behind");

	a_event_sets: assert property (@(posedge pclk) disable iff (!presetn)
		ev != 16'h0000 && !swrst |=> (flags & $past(ev)) == $past(ev))
		else $error("event did not set its flag");

	a_flag_w1c: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == `ASFI_OFS_INTFLAG && (ev & wmask) == 16'h0000
		|=> (flags & $past(wmask)) == 16'h0000)
		else $error("flag write one did not clear");

	a_txrdy_en_clr: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == `ASFI_OFS_IRQ_ENABLE_CLEAR && wmask[`ASFI_IRQ_TXRDY_LO + 1]
		|=> !irq_en[`ASFI_IRQ_TXRDY_LO + 1])
		else $error("transmit ready enable not cleared");

	a_rxor_en_clr: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == `ASFI_OFS_IRQ_ENABLE_CLEAR && wmask[`ASFI_IRQ_RXOR_LO]
		|=> !irq_en[`ASFI_IRQ_RXOR_LO])
		else $error("overrun enable not cleared");

	a_rxrdy_en_clr: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == `ASFI_OFS_IRQ_ENABLE_CLEAR && wmask[`ASFI_IRQ_RXRDY_LO]
		|=> !irq_en[`ASFI_IRQ_RXRDY_LO])
		else $error("receive ready enable not cleared");

	a_txrdy_en_set: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == `ASFI_OFS_IRQ_ENABLE_SET && wmask[`ASFI_IRQ_TXRDY_LO]
		|=> irq_en[`ASFI_IRQ_TXRDY_LO])
		else $error("transmit ready enable not set");

	a_rxor_en_set: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == `ASFI_OFS_IRQ_ENABLE_SET && wmask[`ASFI_IRQ_RXOR_LO + 1]
		|=> irq_en[`ASFI_IRQ_RXOR_LO + 1])
		else $error("overrun enable not set");

	a_rxrdy_en_set: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == `ASFI_OFS_IRQ_ENABLE_SET && wmask[`ASFI_IRQ_RXRDY_LO + 1]
		|=> irq_en[`ASFI_IRQ_RXRDY_LO + 1])
		else $error("receive ready enable not set");

endmodule

// ==== tb/asfi_codec_model.sv ====
`timescale 1ns/10ps
module asfi_codec_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic fs,
	input wire logic data_start,
	output logic sck,
	output logic [15:0] frame_len,
	output logic [15:0] fs_high,
	output logic [15:0] ds_ofs,
	output logic [7:0] n_fs,
	output logic [7:0] n_ds
);
	logic [15:0] cnt;
	logic fs_d;
	// Parked low between runs; offset so edges never meet pclk edges
	initial begin
		sck = 1'b0;
		#3;
		forever begin
			#80;
			sck = run ? ~sck : 1'b0;
		end
	end
	// Measures in pclk cycles from each sync rise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
			fs_d <= 1'b0;
			frame_len <= '0;
			fs_high <= '0;
			ds_ofs <= '0;
			n_fs <= '0;
			n_ds <= '0;
		end else begin
			fs_d <= fs;
			cnt <= (fs && !fs_d) ? 16'h0001 : cnt + 16'h0001;
			if (fs && !fs_d) begin
				frame_len <= cnt;
				n_fs <= n_fs + 8'h01;
			end
			if (!fs && fs_d) begin
				fs_high <= cnt;
			end
			if (data_start) begin
				ds_ofs <= (fs && !fs_d) ? 16'h0000 : cnt;
				n_ds <= n_ds + 8'h01;
			end
		end
	end
endmodule

// ==== tb/asfi_top_tb.sv ====
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
	$display("unexpected %0t: got %0h want %0h", $time, g, e); end end
module asfi_top_tb
	import asfi_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, run, sck, er;
	logic [7:0] paddr, n_fs, n_ds, b_fs, b_ds;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] xfer_req, fs_out, data_start;
	logic [1:0][31:0] rx_sample, tx_sample;
	logic [15:0] frame_len, fs_high, ds_ofs;
	asfi_seq_evt_s seq_evt;
	int n_fail, check_count;
	asfi_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sck_in({sck, sck}), .xfer_req(xfer_req),
		.seq_evt(seq_evt), .rx_sample(rx_sample), .tx_sample(tx_sample),
		.fs_out(fs_out), .data_start(data_start), .irq(irq));
	asfi_codec_model codec (.pclk(pclk), .presetn(presetn), .run(run), .fs(fs_out[0]),
		.data_start(data_start[0]), .sck(sck), .frame_len(frame_len),
		.fs_high(fs_high), .ds_ofs(ds_ofs), .n_fs(n_fs), .n_ds(n_ds));
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_fail++;
			wrap_up;
		end else begin
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(rd, e)
		`CHK(er, 1'b0)
	endtask
	task automatic evt(input logic [7:0] e);
		@(posedge pclk);
		seq_evt <= e;
		@(posedge pclk);
		seq_evt <= 8'h00;
		repeat (2) @(posedge pclk);
		#1;
	endtask
	// Event lands in the same cycle as the write that clears it
	task automatic wr_evt(input logic [7:0] a, input logic [31:0] d, input logic [7:0] e);
		fork
			wr(a, d);
			begin
				repeat (2) @(posedge pclk);
				seq_evt <= e;
				@(posedge pclk);
				seq_evt <= 8'h00;
			end
		join
	endtask
	task automatic wait_fs(input int k);
		int n;
		n = 0;
		while (8'(n_fs - b_fs) < k && n < 20000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 20000) begin
			n_fail++;
			wrap_up;
		end
	endtask
	// One serial bit is 16 pclk cycles
	task automatic frame(input logic [7:0] cfg, input int bits, input int hi, input int dly);
		wr(8'h00, 32'h0000_0000);
		wr(8'h04, {24'h00_0000, cfg});
		rdc(8'h04, {24'h00_0000, cfg});
		wr(8'h00, 32'h0000_0006);
		run <= 1'b1;
		b_fs = n_fs;
		wait_fs(3);
		`CHK(frame_len, 16'(bits * 16))
		`CHK(fs_high, 16'(hi * 16))
		`CHK(ds_ofs, 16'(dly * 16))
		`CHK({fs_out[1], data_start[1]}, 2'b00)
		run <= 1'b0;
		$display("frame cfg %0h done", cfg);
	endtask
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		#900000;
		n_fail++;
		wrap_up;
	end
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, run} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		xfer_req = 2'b00;
		seq_evt = 8'h00;
		rx_sample = {32'hC3C3_0101, 32'h5AA5_7E81};
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rdc(8'h0C, 32'h0000_0000);
		rdc(8'h10, 32'h0000_0000);
		wr(8'h10, 32'h0000_3333);
		rdc(8'h0C, 32'h0000_3333);
		wr(8'h10, 32'h0000_0000);
		rdc(8'h10, 32'h0000_3333);
		wr(8'h0C, 32'h0000_1111);
		rdc(8'h10, 32'h0000_2222);
		wr(8'h0C, 32'h0000_0000);
		rdc(8'h0C, 32'h0000_2222);
		wr(8'h0C, 32'h0000_2222);
		rdc(8'h10, 32'h0000_0000);
		wr(8'h10, 32'h0000_3333);
		wr(8'h00, 32'h0000_0001);
		rdc(8'h0C, 32'h0000_0000);
		apb(1'b0, 8'h40, 32'h0000_0000);
		`CHK(er, 1'b1)
		$display("enable registers done");
		wr(8'h10, 32'h0000_0010);
		evt(8'h04);
		`CHK(irq, 1'b1)
		rdc(8'h14, 32'h0000_0010);
		wr(8'h14, 32'h0000_0010);
		evt(8'h20);
		`CHK(irq, 1'b0)
		rdc(8'h14, 32'h0000_0200);
		wr(8'h34, 32'h1234_5678);
		#1;
		`CHK(tx_sample[1], 32'h1234_5678)
		rdc(8'h14, 32'h0000_0000);
		evt(8'h01);
		rdc(8'h30, 32'h5AA5_7E81);
		rdc(8'h14, 32'h0000_0000);
		wr_evt(8'h14, 32'h0000_0001, 8'h01);
		rdc(8'h14, 32'h0000_0001);
		wr(8'h14, 32'h0000_0001);
		rdc(8'h14, 32'h0000_0000);
		wr(8'h30, 32'hA5A5_0F0F);
		#1;
		`CHK(tx_sample[0], 32'hA5A5_0F0F)
		rdc(8'h34, 32'hC3C3_0101);
		$display("flags done");
		frame(8'h84, 16, 8, 1);
		frame(8'h29, 48, 24, 0);
		frame(8'hC2, 24, 1, 1);
		frame(8'h5F, 256, 1, 0);
		// Plain 8-bit slots only: one slot per burst request, no data delay
		wr(8'h00, 32'h0000_0000);
		wr(8'h04, 32'h0000_0060);
		wr(8'h00, 32'h0000_0006);
		wr(8'h04, 32'h0000_0000);
		rdc(8'h04, 32'h0000_0060);
		run <= 1'b1;
		b_fs = n_fs;
		b_ds = n_ds;
		repeat (800) @(posedge pclk);
		`CHK(n_fs, b_fs)
		xfer_req <= 2'b01;
		@(posedge pclk);
		xfer_req <= 2'b00;
		wait_fs(1);
		repeat (400) @(posedge pclk);
		`CHK(8'(n_fs - b_fs), 8'h01)
		`CHK(8'(n_ds - b_ds), 8'h01)
		`CHK(fs_high, 16'h0010)
		$display("burst done");
		wrap_up;
	end
endmodule
